// ---- common/aoc_map.svh ----
// constant map of the amplifier output configuration register
// assumes an 8-bit control port with byte addresses
`ifndef AOC_MAP_SVH
`define AOC_MAP_SVH
`define AOC_ADDR_CFG        8'h06
`define AOC_ADDR_RSVD       8'h07
`define AOC_CFG_RESET       8'h51
`define AOC_BIT_MONO        7
`define AOC_RATE_HI         6
`define AOC_RATE_LO         4
`define AOC_GAIN_HI         3
`define AOC_GAIN_LO         2
`define AOC_BIT_CHSEL       1
`define AOC_BIT_RSVD        0
`define AOC_RATE_RESET      3'h5
`define AOC_GAIN_RESET      2'h0
`endif

// ---- common/aoc_pkg.sv ----
// types of the amplifier output configuration block
// assumes aoc_map.svh for all numbers
package aoc_pkg;
	// control port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} aoc_req_t;
	// decoded configuration toward the modulator
	typedef struct packed {
		logic       mono_bridge_select;
		logic       mono_source_channel;
		logic [1:0] gain_code;
		logic [4:0] switch_mult;
		logic       switch_halve;
	} aoc_cfg_t;
endpackage

// ---- logic/aoc_cfg_reg.sv ----
// amplifier output configuration register and its decoded controls
// assumes a control port front end giving single-cycle read/write strobes
`timescale 1ns/1ps
`include "aoc_map.svh"
module aoc_cfg_reg
(
	input  wire logic            core_clk,
	input  wire logic            srst,
	input  wire logic            clk_en,
	input  wire aoc_pkg::aoc_req_t req,
	input  wire logic            double_speed,
	output logic           [7:0] rdata,
	output logic                 rvalid,
	output aoc_pkg::aoc_cfg_t    cfg,
	output logic                 mono_sample_is_left
);
	import aoc_pkg::*;

	////////////////////////////////////////////////////////////////
	// register state
	logic [7:0] cfg_r;      // stored register
	logic [7:0] cfg_nxt;    // next value
	logic [7:0] rdata_r;    // read data
	logic [7:0] rdata_nxt;
	logic       rvalid_r;   // read answer pulse
	logic       rvalid_nxt;
	logic [4:0] mult;       // decoded multiple

	// next value: only an exact hit on the register address writes
	always_comb
	begin
		cfg_nxt    = cfg_r;
		rdata_nxt  = rdata_r;
		rvalid_nxt = 1'b0;
		if (req.wr && req.addr == `AOC_ADDR_CFG)
		begin
			cfg_nxt = req.wdata; // all bits stored, reserved too
		end
		if (req.rd)
		begin
			rvalid_nxt = 1'b1;
			// other addresses, the reserved one included, read zero
			if (req.addr == `AOC_ADDR_CFG)
				rdata_nxt = cfg_r;
			else
				rdata_nxt = 8'h00;
		end
	end

	// registers only; clock enable freezes everything but reset
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			cfg_r    <= `AOC_CFG_RESET;
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end
		else if (clk_en)
		begin
			cfg_r    <= cfg_nxt;
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// decode toward the modulator
	aoc_rate_dec u_rate
	(
		.rate_code (cfg_r[`AOC_RATE_HI:`AOC_RATE_LO]),
		.mult      (mult)
	);

	// decoded controls; gain 11 passed through, host must avoid it
	always_comb
	begin
		cfg.mono_bridge_select  = cfg_r[`AOC_BIT_MONO];
		cfg.mono_source_channel = cfg_r[`AOC_BIT_CHSEL];
		cfg.gain_code           = cfg_r[`AOC_GAIN_HI:`AOC_GAIN_LO];
		cfg.switch_mult         = mult;
		cfg.switch_halve        = double_speed;
		// left only in mono with select set, else right
		mono_sample_is_left     = cfg_r[`AOC_BIT_MONO] & cfg_r[`AOC_BIT_CHSEL];
	end

	assign rdata  = rdata_r;
	assign rvalid = rvalid_r;

	////////////////////////////////////////////////////////////////
	// checks
	a_write_stores: assert property (@(posedge core_clk) disable iff (srst)
		clk_en && req.wr && req.addr == `AOC_ADDR_CFG |=> cfg_r == $past(req.wdata))
		else $error("write to config not stored");
	a_read_back: assert property (@(posedge core_clk) disable iff (srst)
		clk_en && req.rd && req.addr == `AOC_ADDR_CFG |=> rvalid && rdata == $past(cfg_r))
		else $error("read returned wrong value");
	a_other_no_write: assert property (@(posedge core_clk) disable iff (srst)
		req.wr && req.addr != `AOC_ADDR_CFG |=> $stable(cfg_r))
		else $error("config changed by other address");
	a_reset_value: assert property (@(posedge core_clk)
		srst |=> cfg_r == `AOC_CFG_RESET)
		else $error("bad reset value");
	a_mono_select: assert property (@(posedge core_clk) disable iff (srst)
		cfg.mono_bridge_select == cfg_r[7])
		else $error("mode select wrong");
	a_rate_default: assert property (@(posedge core_clk) disable iff (srst)
		cfg_r[6:4] == 3'h5 |-> cfg.switch_mult == 5'h10)
		else $error("rate decode wrong");
	a_source_left: assert property (@(posedge core_clk) disable iff (srst)
		cfg_r[7] && cfg_r[1] |-> mono_sample_is_left)
		else $error("left source not chosen");
	a_source_right: assert property (@(posedge core_clk) disable iff (srst)
		!cfg_r[1] |-> !mono_sample_is_left)
		else $error("right source not chosen");
	a_speed_halve: assert property (@(posedge core_clk) disable iff (srst)
		cfg.switch_halve == double_speed)
		else $error("halving not applied");
	a_gain_field: assert property (@(posedge core_clk) disable iff (srst)
		cfg.gain_code == cfg_r[3:2])
		else $error("gain field wrong");
	c_mono_write: cover property (@(posedge core_clk) req.wr && req.addr == 8'h06 && req.wdata[7]);
	c_read_cfg: cover property (@(posedge core_clk) rvalid && rdata != 8'h51);
	c_double_speed: cover property (@(posedge core_clk) double_speed && cfg.switch_mult == 5'h18);

	////////////////////////////////////////////////////////////////
	// further checks on the decode and the read path
	// the modulator fed by these controls lives outside this block
	// decode table, one property per code; a single table-driven check
	// would only mirror the decoder, so each code is pinned by hand
	a_rate_six: assert property (@(posedge core_clk) disable iff (srst)
		cfg_r[`AOC_RATE_HI:`AOC_RATE_LO] == 3'h0 |-> cfg.switch_mult == 5'h06)
		else $error("rate code 0 decoded wrong");
	a_rate_eight: assert property (@(posedge core_clk) disable iff (srst)
		cfg_r[`AOC_RATE_HI:`AOC_RATE_LO] == 3'h1 |-> cfg.switch_mult == 5'h08)
		else $error("rate code 1 decoded wrong");
	a_rate_ten: assert property (@(posedge core_clk) disable iff (srst)
		cfg_r[`AOC_RATE_HI:`AOC_RATE_LO] == 3'h2 |-> cfg.switch_mult == 5'h0A)
		else $error("rate code 2 decoded wrong");
	a_rate_twelve: assert property (@(posedge core_clk) disable iff (srst)
		cfg_r[`AOC_RATE_HI:`AOC_RATE_LO] == 3'h3 |-> cfg.switch_mult == 5'h0C)
		else $error("rate code 3 decoded wrong");
	a_rate_fourteen: assert property (@(posedge core_clk) disable iff (srst)
		cfg_r[`AOC_RATE_HI:`AOC_RATE_LO] == 3'h4 |-> cfg.switch_mult == 5'h0E)
		else $error("rate code 4 decoded wrong");
	a_rate_twenty: assert property (@(posedge core_clk) disable iff (srst)
		cfg_r[`AOC_RATE_HI:`AOC_RATE_LO] == 3'h6 |-> cfg.switch_mult == 5'h14)
		else $error("rate code 6 decoded wrong");
	a_rate_twentyfour: assert property (@(posedge core_clk) disable iff (srst)
		cfg_r[`AOC_RATE_HI:`AOC_RATE_LO] == 3'h7 |-> cfg.switch_mult == 5'h18)
		else $error("rate code 7 decoded wrong");

	// any code lands on an even multiple from 6 to 24; a bad decoder
	// entry shows up here even between writes
	a_mult_range: assert property (@(posedge core_clk) disable iff (srst)
		cfg.switch_mult >= 5'h06 && cfg.switch_mult <= 5'h18)
		else $error("switching multiple out of range");
	a_mult_even: assert property (@(posedge core_clk) disable iff (srst)
		!cfg.switch_mult[0])
		else $error("switching multiple odd");

	// channel routing: stereo never flags the left channel, and the
	// select bit reaches the modulator unchanged in every mode
	a_stereo_right: assert property (@(posedge core_clk) disable iff (srst)
		!cfg_r[`AOC_BIT_MONO] |-> !mono_sample_is_left)
		else $error("left source flagged in stereo");
	a_channel_field: assert property (@(posedge core_clk) disable iff (srst)
		cfg.mono_source_channel == cfg_r[`AOC_BIT_CHSEL])
		else $error("channel select not passed on");

	// read path: unmapped addresses answer zero, the answer is a single
	// pulse, and the data stays put until the next taken read
	a_other_reads_zero: assert property (@(posedge core_clk) disable iff (srst)
		clk_en && req.rd && req.addr != `AOC_ADDR_CFG |=> rvalid && rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rvalid_pulse: assert property (@(posedge core_clk) disable iff (srst)
		clk_en && !req.rd |=> !rvalid)
		else $error("read answer longer than one cycle");
	a_rdata_hold: assert property (@(posedge core_clk) disable iff (srst)
		clk_en && !req.rd |=> $stable(rdata))
		else $error("read data moved without a read");

	// hold and freeze: only a taken write to the register moves it; a low
	// clock enable must also hold the read answer, or a paused host would
	// see a pulse it never asked for
	a_cfg_hold: assert property (@(posedge core_clk) disable iff (srst)
		!(clk_en && req.wr && req.addr == `AOC_ADDR_CFG) |=> $stable(cfg_r))
		else $error("config moved without a write");
	a_freeze_cfg: assert property (@(posedge core_clk) disable iff (srst)
		!clk_en |=> $stable(cfg_r))
		else $error("config moved while frozen");
	a_freeze_read: assert property (@(posedge core_clk) disable iff (srst)
		!clk_en |=> $stable(rvalid) && $stable(rdata))
		else $error("read answer moved while frozen");

	// reset: no stale answer survives, and the reserved bit comes back set
	// even if a host cleared it before the reset; reset is not gated by
	// the clock enable, so these hold with the block frozen as well
	a_reset_read: assert property (@(posedge core_clk)
		srst |=> !rvalid && rdata == 8'h00)
		else $error("read answer survived reset");
	a_reserved_reset: assert property (@(posedge core_clk)
		srst |=> cfg_r[`AOC_BIT_RSVD])
		else $error("reserved bit not set by reset");

	// further covers: a write refused by the clock enable, and the left
	// source in use
	c_freeze_write: cover property (@(posedge core_clk) !clk_en && req.wr);
	c_left_source: cover property (@(posedge core_clk) mono_sample_is_left);
endmodule

// ---- logic/aoc_rate_dec.sv ----
// switching rate decoder: code to multiple of the frame clock
// assumes a static code from the same clock domain
`timescale 1ns/1ps
module aoc_rate_dec
(
	input  wire logic [2:0] rate_code,
	output logic      [4:0] mult
);
	// fixed table of multiples
	always_comb
	begin
		case (rate_code)
			3'h0:    mult = 5'h06;
			3'h1:    mult = 5'h08;
			3'h2:    mult = 5'h0A;
			3'h3:    mult = 5'h0C;
			3'h4:    mult = 5'h0E;
			3'h5:    mult = 5'h10;
			3'h6:    mult = 5'h14;
			default: mult = 5'h18;
		endcase
	end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the amplifier output configuration register
// assumes aoc_pkg and a single 100 MHz clock with synchronous reset
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_top;
	import aoc_pkg::*;
	logic               core_clk = 1'b0;   // 10 ns period
	logic               srst = 1'b1;       // held for 12 cycles
	logic               clk_en = 1'b1;     // run enable
	logic               double_speed = 1'b0;
	aoc_req_t           req = '0;          // one-cycle strobes
	logic         [7:0] rdata;
	logic               rvalid;
	aoc_cfg_t           cfg;
	logic               mono_sample_is_left;
	int                 fail_count = 0;
	int                 n_checks = 0;
	logic         [4:0] mult_tab [8] = '{5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18};
	logic         [7:0] mono_tab [3] = '{8'h83, 8'h81, 8'h03};
	logic         [7:0] v;
	always #5 core_clk = ~core_clk;
	aoc_cfg_reg i_aoc_cfg_reg
	(
		.core_clk            (core_clk),
		.srst                (srst),
		.clk_en              (clk_en),
		.req                 (req),
		.double_speed        (double_speed),
		.rdata               (rdata),
		.rvalid              (rvalid),
		.cfg                 (cfg),
		.mono_sample_is_left (mono_sample_is_left)
	);
	////////////////////////////////////////////////////////////////////////
	// write: strobe for one cycle, new value is visible after the taking edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) req <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk) req <= '0;
		#1;
	endtask
	// read: answer expected just after the taking edge, bounded wait for safety
	task rd(input logic [7:0] a, input logic [7:0] e);
		int i;
		@(posedge core_clk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk) req <= '0;
		#1;
		for (i = 0; i < 4 && rvalid !== 1'b1; i++)
		begin
			@(posedge core_clk);
			#1;
		end
		`CHK(rvalid, 1'b1)
		`CHK(rdata, e)
		// a missing answer ends the run at once
		if (rvalid !== 1'b1)
			test_done;
	endtask
	// verdict, reached from the main sequence, the watchdog or a missing read answer
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog: a hang counts as a mismatch
	initial
	begin
		#100000;
		fail_count++;
		test_done;
	end
	initial
	begin
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		rd(8'h06, 8'h51);
		`CHK(cfg.switch_mult, 5'h10)
		`CHK(cfg.mono_bridge_select, 1'b0)
		`CHK(cfg.gain_code, 2'h0)
		`CHK(mono_sample_is_left, 1'b0)
		$display("reset values done");
		// every rate code, bit 0 kept at one
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h06, {1'b0, c[2:0], 4'h1});
			`CHK(cfg.switch_mult, mult_tab[c])
		end
		$display("rate codes done");
		// only the three legal gain codes are written by the host
		for (int g = 0; g < 3; g++)
		begin
			wr(8'h06, {4'h5, g[1:0], 2'h1});
			`CHK(cfg.gain_code, g[1:0])
			rd(8'h06, {4'h5, g[1:0], 2'h1});
		end
		$display("gain codes done");
		for (int m = 0; m < 3; m++)
		begin
			v = mono_tab[m];
			wr(8'h06, v);
			`CHK(cfg.mono_bridge_select, v[7])
			`CHK(cfg.mono_source_channel, v[1])
			`CHK(mono_sample_is_left, v[7] & v[1])
		end
		$display("mono modes done");
		// fastest rate code while double speed is raised
		wr(8'h06, 8'h71);
		`CHK(cfg.switch_mult, 5'h18)
		@(posedge core_clk) double_speed <= 1'b1;
		@(posedge core_clk) #1;
		`CHK(cfg.switch_halve, 1'b1)
		@(posedge core_clk) double_speed <= 1'b0;
		@(posedge core_clk) #1;
		`CHK(cfg.switch_halve, 1'b0)
		$display("double speed done");
		// unmapped address must not touch the register; the reserved one is never used
		wr(8'h26, 8'h00);
		rd(8'h26, 8'h00);
		rd(8'h06, 8'h71);
		// frozen cycle ignores a write
		@(posedge core_clk) clk_en <= 1'b0;
		wr(8'h06, 8'hE5);
		@(posedge core_clk) clk_en <= 1'b1;
		rd(8'h06, 8'h71);
		$display("refusals done");
		// mid-run reset brings the defaults back
		@(posedge core_clk) srst <= 1'b1;
		@(posedge core_clk) srst <= 1'b0;
		rd(8'h06, 8'h51);
		`CHK(cfg.switch_mult, 5'h10)
		`CHK(mono_sample_is_left, 1'b0)
		$display("mid-run reset done");
		test_done;
	end
endmodule
